// ===== rtl/debug_port_instruction_engine.sv
// instruction engine of the single-wire program and debug port
// assumes a uart phy that measures the baud sync character, delivers
// received bytes, pulses one tick per bit period and sends bytes on request
//
// Operation
// - indirect write operands are one or two bytes
// - pointer mode 2 loads pointer, then acknowledges
// - mode 0 writes at pointer, mode 1 post-increments
// - acknowledge after every successful indirect write
// - one repeated data frame per acknowledge
// - cs read addresses 16 bytes, returns one byte
// - cs read answer waits out guard time
// - cs write takes one byte to 16-byte space
// - cs write sends no response
// - repeat reruns next instruction on operands only
// - repeat instruction itself is never repeated
// - one-byte count, instruction runs count plus one
// - repeat runs to end unless break arrives
// - repeated indirect writes keep acknowledging
// - mode 0 writes the same address every iteration
// - key accepts only eight-byte keys
// - info block select transmits up to sixteen bytes
// - key length sets frame count, keys unanswered
// - info block transmission waits out guard time
// - guard time is idle bits before first start
// - sync character precedes each instruction
module debug_port_instruction_engine
	import dbg_pkg::*;
(
	input wire logic ref_clk, // 125 MHz clock
	input wire logic reset, // async reset, high
	input wire logic rxValid, // received byte valid
	input wire logic [7:0] rxData, // received byte
	output logic rxReady, // receive fifo has room
	input wire logic syncSeen, // pulse: phy measured a valid sync character
	input wire logic breakSeen, // pulse: phy saw a break character
	input wire logic bitTick, // pulse: one bit period at current baud
	input wire logic [GUARD_W-1:0] guardIdleCount, // idle bits before answering
	output logic txValid, // byte to send
	output logic [7:0] txData, // byte to send, registered
	input wire logic txReady, // phy takes the byte
	output logic txTurn, // high while line faces transmit
	output logic busReq, // bus write request, held until done
	output logic [15:0] busAddr, // bus address, registered pointer
	output logic [15:0] busWdata, // bus write data, registered
	output logic busWide, // two-byte bus write
	input wire logic busDone, // pulse: bus write completed
	output logic csWrite, // pulse: control and status write
	output logic [3:0] csAddr, // control and status address, registered
	output logic [7:0] csWdata, // control and status write data, registered
	input wire logic [7:0] csRdata, // control and status read data for csAddr
	output logic keyValid, // pulse: eight key bytes received
	output logic [63:0] keyData, // key bytes, first byte lowest
	input wire logic [127:0] sibData, // system info block, byte 0 lowest
	output logic [15:0] pointer, // address pointer, registered
	output logic repeatActive, // repeat in progress, registered
	output logic badOp // pulse: invalid or unsupported instruction
);
	typedef enum logic [3:0] {
		S_SYNC, S_OPCODE, S_RPT, S_OPERAND, S_BUS, S_CSDATA,
		S_KEY, S_GUARD, S_SEND, S_DROP
	} state_e;

	typedef enum logic [1:0] {TX_ACK, TX_CS, TX_SIB} tx_e;

	byte_stream_if #(.W(8)) inStream ();
	byte_stream_if #(.W(8)) outStream ();

	assign inStream.valid = rxValid;
	assign inStream.data = rxData;
	assign rxReady = inStream.ready;

	// the fifo lets the phy run ahead while the engine waits on the bus
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.fill(inStream),
		.drain(outStream)
	);

	function automatic logic [4:0] sizeBytes(input logic [1:0] sz);
		return (sz == SIZE_WORD) ? 5'h02 : 5'h01;
	endfunction

	// opcodes this engine executes with legal field encodings
	function automatic logic opValid(input logic [7:0] op);
		logic [2:0] cls;
		logic [1:0] pm;
		logic [1:0] sz;
		cls = op[OPC_MSB:OPC_LSB];
		pm = op[PTR_MSB:PTR_LSB];
		sz = op[SIZE_MSB:SIZE_LSB];
		unique case (cls)
			OP_INDIRECT_WRITE: return (pm != 2'h3) && (sz <= SIZE_WORD);
			OP_CS_READ, OP_CS_WRITE: return 1'b1;
			OP_REPEAT: return sz == SIZE_BYTE;
			OP_KEY: return (sz == KEYSZ_8) || (sz == KEYSZ_16 && op[KEY_SIB_BIT]);
			default: return 1'b0;
		endcase
	endfunction

	// state that begins the operand phase; repeats re-enter here
	function automatic state_e startOf(input logic [7:0] op);
		unique case (op[OPC_MSB:OPC_LSB])
			OP_INDIRECT_WRITE: return S_OPERAND;
			OP_CS_READ: return S_GUARD;
			OP_CS_WRITE: return S_CSDATA;
			OP_REPEAT: return S_RPT;
			OP_KEY: return op[KEY_SIB_BIT] ? S_GUARD : S_KEY;
			default: return S_DROP;
		endcase
	endfunction

	function automatic logic [4:0] operandCount(input logic [7:0] op);
		unique case (op[OPC_MSB:OPC_LSB])
			OP_INDIRECT_WRITE: return sizeBytes(op[SIZE_MSB:SIZE_LSB]);
			OP_KEY: return (op[SIZE_MSB:SIZE_LSB] == KEYSZ_16) ? SIB_BYTES : KEY_BYTES;
			default: return 5'h01;
		endcase
	endfunction

	function automatic tx_e txKindOf(input logic [7:0] op);
		unique case (op[OPC_MSB:OPC_LSB])
			OP_CS_READ: return TX_CS;
			OP_KEY: return TX_SIB;
			default: return TX_ACK;
		endcase
	endfunction

	state_e state, next_state;
	tx_e txKind, next_txKind;
	logic [7:0] opReg, next_opReg;
	logic [7:0] rptLeft, next_rptLeft;
	logic armRepeat, next_armRepeat;
	logic next_repeatActive;
	logic [4:0] bytesLeft, next_bytesLeft;
	logic [4:0] sibIdx, next_sibIdx;
	logic [63:0] collect, next_collect;
	logic [GUARD_W-1:0] guardCnt, next_guardCnt;
	logic [15:0] next_pointer;
	logic [15:0] next_busWdata;
	logic next_busWide;
	logic [7:0] next_txData;
	logic [3:0] next_csAddr;
	logic [7:0] next_csWdata;
	logic next_csWrite;
	logic next_keyValid;
	logic [63:0] next_keyData;
	logic next_badOp;

	wire haveByte = outStream.valid;
	wire [7:0] inByte = outStream.data;
	wire [2:0] opClass = opReg[OPC_MSB:OPC_LSB];
	wire [1:0] ptrMode = opReg[PTR_MSB:PTR_LSB];
	wire opWide = opReg[SIZE_MSB:SIZE_LSB] == SIZE_WORD;
	wire [15:0] stepSize = opWide ? 16'h0002 : 16'h0001;
	// bytes arrive low first into the top of the shift register
	wire [63:0] shifted = {inByte, collect[63:8]};
	wire [15:0] operandWord = opWide ? shifted[63:48] : {8'h00, shifted[63:56]};
	wire lastOperand = (bytesLeft == 5'h01);
	wire guardDone = (guardCnt == guardIdleCount);
	wire [7:0] sibByte = sibData[{sibIdx[3:0], 3'b000} +: 8];
	wire sibLast = (sibIdx == operandCount(opReg) - 5'h01);
	wire moreRepeats = repeatActive && (rptLeft != 8'h00);

	// the sync state also discards stray bytes so the fifo cannot clog
	assign outStream.ready = (state == S_SYNC) || (state == S_OPCODE) ||
		(state == S_RPT) || (state == S_OPERAND) || (state == S_CSDATA) ||
		(state == S_KEY) || (state == S_DROP);
	assign txValid = (state == S_SEND);
	assign txTurn = (state == S_GUARD) || (state == S_SEND);
	assign busReq = (state == S_BUS);
	assign busAddr = pointer;

	always_comb
	begin
		next_state = state;
		next_txKind = txKind;
		next_opReg = opReg;
		next_rptLeft = rptLeft;
		next_armRepeat = armRepeat;
		next_repeatActive = repeatActive;
		next_bytesLeft = bytesLeft;
		next_sibIdx = sibIdx;
		next_collect = collect;
		next_guardCnt = guardCnt;
		next_pointer = pointer;
		next_busWdata = busWdata;
		next_busWide = busWide;
		next_txData = txData;
		next_csAddr = csAddr;
		next_csWdata = csWdata;
		next_csWrite = 1'b0;
		next_keyValid = 1'b0;
		next_keyData = keyData;
		next_badOp = 1'b0;
		unique case (state)
			S_SYNC:
			begin
				if (syncSeen)
					next_state = S_OPCODE;
			end
			S_OPCODE:
			begin
				if (haveByte)
				begin
					next_opReg = inByte;
					next_bytesLeft = operandCount(inByte);
					next_csAddr = inByte[CSA_MSB:0];
					next_txKind = txKindOf(inByte);
					next_sibIdx = 5'h00;
					next_guardCnt = '0;
					if (!opValid(inByte))
					begin
						next_badOp = 1'b1;
						next_armRepeat = 1'b0;
						next_state = S_DROP;
					end
					else
					begin
						next_state = startOf(inByte);
						// a repeat reloads the count and is not itself repeated
						if (armRepeat && inByte[OPC_MSB:OPC_LSB] != OP_REPEAT)
						begin
							next_repeatActive = 1'b1;
							next_armRepeat = 1'b0;
						end
					end
				end
			end
			S_RPT:
			begin
				if (haveByte)
				begin
					next_rptLeft = inByte;
					next_armRepeat = 1'b1;
					next_state = S_SYNC;
				end
			end
			S_OPERAND:
			begin
				if (haveByte)
				begin
					next_collect = shifted;
					next_bytesLeft = bytesLeft - 5'h01;
					if (lastOperand)
					begin
						next_bytesLeft = operandCount(opReg);
						if (ptrMode == PTR_LOAD)
						begin
							next_pointer = operandWord;
							next_state = S_GUARD;
						end
						else
						begin
							// pointer is whatever the host loaded earlier
							next_busWdata = operandWord;
							next_busWide = opWide;
							next_state = S_BUS;
						end
					end
				end
			end
			S_BUS:
			begin
				if (busDone)
				begin
					if (ptrMode == PTR_POSTINC)
						next_pointer = pointer + stepSize;
					next_state = S_GUARD;
				end
			end
			S_CSDATA:
			begin
				if (haveByte)
				begin
					next_csWdata = inByte;
					next_csWrite = 1'b1;
					if (moreRepeats)
						next_rptLeft = rptLeft - 8'h01;
					else
						next_repeatActive = 1'b0;
					next_state = moreRepeats ? S_CSDATA : S_SYNC;
				end
			end
			S_KEY:
			begin
				if (haveByte)
				begin
					next_collect = shifted;
					next_bytesLeft = bytesLeft - 5'h01;
					if (lastOperand)
					begin
						next_keyData = shifted;
						next_keyValid = 1'b1;
						next_bytesLeft = operandCount(opReg);
						if (moreRepeats)
							next_rptLeft = rptLeft - 8'h01;
						else
							next_repeatActive = 1'b0;
						next_state = moreRepeats ? S_KEY : S_SYNC;
					end
				end
			end
			S_GUARD:
			begin
				// idle bits counted at the current baud before the first start bit
				if (guardDone)
				begin
					next_state = S_SEND;
					unique case (txKind)
						TX_ACK: next_txData = ACK_CHAR;
						TX_CS: next_txData = csRdata;
						TX_SIB: next_txData = sibByte;
					endcase
				end
				else if (bitTick)
					next_guardCnt = guardCnt + GUARD_W'(1);
			end
			S_SEND:
			begin
				if (txReady)
				begin
					next_guardCnt = '0;
					if (txKind == TX_SIB && !sibLast)
					begin
						// back-to-back info bytes need no new guard time
						next_sibIdx = sibIdx + 5'h01;
						next_txData = sibData[{next_sibIdx[3:0], 3'b000} +: 8];
					end
					else
					begin
						next_sibIdx = 5'h00;
						if (moreRepeats)
						begin
							// the next data frame is taken only after this answer
							next_rptLeft = rptLeft - 8'h01;
							next_state = startOf(opReg);
						end
						else
						begin
							next_repeatActive = 1'b0;
							next_state = S_SYNC;
						end
					end
				end
			end
			S_DROP:
			begin
				// bytes after a bad instruction are discarded until resync
				next_repeatActive = 1'b0;
				if (syncSeen)
					next_state = S_OPCODE;
			end
			default:
				next_state = S_SYNC;
		endcase
		// only a break ends a running repeat early
		if (breakSeen)
		begin
			next_state = S_SYNC;
			next_repeatActive = 1'b0;
			next_armRepeat = 1'b0;
			next_rptLeft = RESET_RPT;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state <= S_SYNC;
			txKind <= TX_ACK;
			opReg <= 8'h00;
			rptLeft <= RESET_RPT;
			armRepeat <= 1'b0;
			repeatActive <= 1'b0;
			bytesLeft <= 5'h01;
			sibIdx <= 5'h00;
			collect <= 64'h0;
			guardCnt <= '0;
		end
		else
		begin
			state <= next_state;
			txKind <= next_txKind;
			opReg <= next_opReg;
			rptLeft <= next_rptLeft;
			armRepeat <= next_armRepeat;
			repeatActive <= next_repeatActive;
			bytesLeft <= next_bytesLeft;
			sibIdx <= next_sibIdx;
			collect <= next_collect;
			guardCnt <= next_guardCnt;
		end
	end

	// in mode 0 the pointer stays put across iterations; mode 2 reloads it from each frame
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			pointer <= RESET_PTR;
			busWdata <= 16'h0000;
			busWide <= 1'b0;
			txData <= 8'h00;
			csAddr <= 4'h0;
			csWdata <= 8'h00;
			csWrite <= 1'b0;
			keyValid <= 1'b0;
			keyData <= 64'h0;
			badOp <= 1'b0;
		end
		else
		begin
			pointer <= next_pointer;
			busWdata <= next_busWdata;
			busWide <= next_busWide;
			txData <= next_txData;
			csAddr <= next_csAddr;
			csWdata <= next_csWdata;
			csWrite <= next_csWrite;
			keyValid <= next_keyValid;
			keyData <= next_keyData;
			badOp <= next_badOp;
		end
	end
endmodule

// ===== include/dbg_pkg.sv
// constants shared by the debug port instruction engine and its fifo
// assumes a byte-wide receive path and transmit path from a separate uart phy
package dbg_pkg;
	// opcode class in bits [7:5]; values are plain defaults
	localparam int OPC_MSB = 7;
	localparam int OPC_LSB = 5;
	localparam logic [2:0] OP_DIRECT_READ = 3'h0;
	localparam logic [2:0] OP_INDIRECT_READ = 3'h1;
	localparam logic [2:0] OP_DIRECT_WRITE = 3'h2;
	localparam logic [2:0] OP_INDIRECT_WRITE = 3'h3;
	localparam logic [2:0] OP_CS_READ = 3'h4;
	localparam logic [2:0] OP_REPEAT = 3'h5;
	localparam logic [2:0] OP_CS_WRITE = 3'h6;
	localparam logic [2:0] OP_KEY = 3'h7;
	// operand fields
	localparam int PTR_MSB = 3;
	localparam int PTR_LSB = 2;
	localparam int SIZE_MSB = 1;
	localparam int SIZE_LSB = 0;
	localparam int CSA_MSB = 3;
	localparam int KEY_SIB_BIT = 2;
	localparam logic [1:0] PTR_AT = 2'h0;
	localparam logic [1:0] PTR_POSTINC = 2'h1;
	localparam logic [1:0] PTR_LOAD = 2'h2;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] KEYSZ_8 = 2'h0;
	localparam logic [1:0] KEYSZ_16 = 2'h1;
	// answers and counts
	localparam logic [7:0] ACK_CHAR = 8'h40;
	localparam logic [4:0] KEY_BYTES = 5'h08;
	localparam logic [4:0] SIB_BYTES = 5'h10;
	localparam int CS_WORDS = 16;
	localparam int GUARD_W = 3;
	localparam int FIFO_DEPTH = 16;
	// reset values
	localparam logic [15:0] RESET_PTR = 16'h0000;
	localparam logic [7:0] RESET_RPT = 8'h00;
endpackage

// ===== include/byte_stream_if.sv
// valid/ready byte stream between the engine and its receive fifo
// assumes both ends share one clock
interface byte_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; fill and drain may act in the same cycle
module byte_fifo
	import dbg_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input wire logic ref_clk, // clock
	input wire logic reset, // async reset, high
	byte_stream_if.snk fill, // write side
	byte_stream_if.src drain // read side
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("byte_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;
	wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	wire empty = (wrPtr == rdPtr);
	wire doPush = fill.valid && !full;
	wire doPop = drain.ready && !empty;

	assign fill.ready = !full;
	assign drain.valid = !empty;
	assign drain.data = mem[rdPtr[AW-1:0]];

	always_ff @(posedge ref_clk)
	begin
		if (doPush)
			mem[wrPtr[AW-1:0]] <= fill.data;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr <= wrPtr + (AW+1)'(1);
			if (doPop)
				rdPtr <= rdPtr + (AW+1)'(1);
		end
	end
endmodule

// ===== dv/debug_port_asserts.sv
// port-level checks of the debug port instruction engine
// assumes bitTick pulses regularly and every frame ends well inside 300 cycles
module debug_port_asserts
	import dbg_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic reset, // async reset, high
	input wire logic breakSeen, // break pulse
	input wire logic bitTick, // bit period pulse
	input wire logic [GUARD_W-1:0] guardIdleCount, // guard bits
	input wire logic txValid, // byte offered
	input wire logic [7:0] txData, // byte offered
	input wire logic txReady, // byte taken
	input wire logic txTurn, // line faces transmit
	input wire logic busReq, // bus write request
	input wire logic [15:0] busAddr, // bus address
	input wire logic [15:0] busWdata, // bus data
	input wire logic busDone, // bus write done
	input wire logic csWrite, // cs write pulse
	input wire logic keyValid, // key pulse
	input wire logic [15:0] pointer, // address pointer
	input wire logic repeatActive, // repeat running
	input wire logic badOp // invalid instruction
);
	logic sentInTurn;
	logic [3:0] gtick;
	// only the first byte of a turn is checked against the guard
	wire inGuard = txTurn && !txValid && !sentInTurn;
	// the engine offers its byte one cycle after the tick count reaches the setting
	wire guardLast = (gtick == 4'(guardIdleCount));

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			gtick <= 4'h0;
			sentInTurn <= 1'b0;
		end
		else
		begin
			gtick <= inGuard ? gtick + 4'(bitTick) : 4'h0;
			sentInTurn <= txTurn && (sentInTurn || txValid);
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	sequence ackSeq;
		##[0:300] (txValid && txData == ACK_CHAR);
	endsequence
	sequence quietSeq;
		!txTurn [*6];
	endsequence

	AST_GUARD_END: assert property (inGuard && guardLast |=> txValid)
		else $error("guard time overran");
	AST_GUARD_WAIT: assert property (inGuard && !guardLast |=> !txValid)
		else $error("transmit started inside guard time");
	AST_TX_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("tx byte withdrawn before taken");
	AST_BUS_HOLD: assert property (busReq && !busDone |=> busReq && $stable({busAddr, busWdata}))
		else $error("bus request changed before done");
	AST_BUS_PTR: assert property (busReq |-> busAddr == pointer)
		else $error("bus address is not the pointer");
	AST_BUS_ACK: assert property (busReq && busDone |=> !busReq throughout ackSeq)
		else $error("no ack after bus write");
	AST_CSW_QUIET: assert property (csWrite |-> quietSeq)
		else $error("response after cs write");
	AST_KEY_QUIET: assert property (keyValid |-> quietSeq)
		else $error("response after key");
	AST_BAD_NOBUS: assert property (badOp |-> !busReq [*8])
		else $error("bus access on invalid instruction");
	AST_BREAK: assert property (breakSeen |=> !repeatActive && !txTurn && !busReq)
		else $error("break did not abort");
endmodule

// ===== dv/debugger_model.sv
// behavioural debugger standing behind the uart phy
// assumes calls are made just after a falling clock edge
module debugger_model
(
	input wire logic ref_clk, // clock
	input wire logic rxReady, // engine has room
	input wire logic txValid, // byte offered
	input wire logic [7:0] txData, // byte offered
	output logic rxValid, // byte to engine
	output logic [7:0] rxData, // byte to engine
	output logic syncSeen, // sync pulse
	output logic breakSeen, // break pulse
	output logic bitTick, // bit period pulse
	output logic txReady // byte taken
);
	timeunit 1ns;
	timeprecision 1ps;
	int slow = 0;
	int stuck = 0;
	logic [1:0] div = 2'h0;

	initial
	begin
		rxValid = 1'b0;
		rxData = 8'hA5;
		syncSeen = 1'b0;
		breakSeen = 1'b0;
		bitTick = 1'b0;
		txReady = 1'b0;
	end

	always @(negedge ref_clk)
	begin
		div <= div + 2'h1;
		bitTick <= (div == 2'h3);
	end

	task automatic pulse(input logic brk);
		syncSeen = !brk;
		breakSeen = brk;
		@(negedge ref_clk);
		syncSeen = 1'b0;
		breakSeen = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic put(input logic [7:0] b);
		rxValid = 1'b1;
		rxData = b;
		for (int i = 0; i < 500 && !rxReady; i++)
			@(negedge ref_clk);
		if (!rxReady)
			stuck++;
		@(negedge ref_clk);
		rxValid = 1'b0;
		// released line must not look like the last byte
		rxData = ~b;
		@(negedge ref_clk);
	endtask

	task automatic get(output logic [7:0] b);
		b = 'x;
		for (int i = 0; i < 600 && !txValid; i++)
			@(negedge ref_clk);
		if (slow != 0)
			repeat (3) @(negedge ref_clk);
		if (txValid)
		begin
			txReady = 1'b1;
			b = txData;
			@(negedge ref_clk);
			txReady = 1'b0;
			@(negedge ref_clk);
		end
	endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the debug port instruction engine
// assumes the debugger model plays the phy; the bench plays bus and cs space
module tb_top
	import dbg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic busDone = 1'b0;
	logic fire;
	logic [GUARD_W-1:0] guardIdleCount = '0;
	logic [127:0] sibData = '0;
	wire logic rxValid, rxReady, syncSeen, breakSeen, bitTick, txValid, txReady, txTurn;
	wire logic busReq, busWide, csWrite, keyValid, repeatActive, badOp;
	wire logic [7:0] rxData, txData, csWdata, csRdata;
	wire logic [15:0] busAddr, busWdata, pointer;
	wire logic [3:0] csAddr;
	wire logic [63:0] keyData;
	int seed = 2, bad_count = 0, total_checks = 0, lat = 0, busLat = 1;
	int badM = 0, badSeen = 0, keyCnt = 0;
	logic [15:0] ptrM = '0;
	logic [63:0] expKey = '0;
	logic [32:0] expBus[$];
	logic [11:0] expCs[$];
	logic [7:0] badOps[10] = '{8'h62, 8'h63, 8'h6E, 8'hE1, 8'hE2, 8'hA1, 8'h00, 8'h20, 8'h40, 8'h6A};

	always #4 ref_clk = ~ref_clk;
	assign csRdata = {4'h5, csAddr};

	debug_port_instruction_engine i_dut (.ref_clk(ref_clk), .reset(reset),
		.rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .syncSeen(syncSeen),
		.breakSeen(breakSeen), .bitTick(bitTick), .guardIdleCount(guardIdleCount),
		.txValid(txValid), .txData(txData), .txReady(txReady), .txTurn(txTurn),
		.busReq(busReq), .busAddr(busAddr), .busWdata(busWdata), .busWide(busWide),
		.busDone(busDone), .csWrite(csWrite), .csAddr(csAddr), .csWdata(csWdata),
		.csRdata(csRdata), .keyValid(keyValid), .keyData(keyData), .sibData(sibData),
		.pointer(pointer), .repeatActive(repeatActive), .badOp(badOp));
	debugger_model i_host (.ref_clk(ref_clk), .rxReady(rxReady), .txValid(txValid),
		.txData(txData), .rxValid(rxValid), .rxData(rxData), .syncSeen(syncSeen),
		.breakSeen(breakSeen), .bitTick(bitTick), .txReady(txReady));

	task automatic chk(input string what, input logic [127:0] e, input logic [127:0] s);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", what, e, s);
		end
	endtask

	task automatic chk_tx(input logic [7:0] e);
		logic [7:0] b;
		i_host.get(b);
		chk("tx byte", e, b);
	endtask

	task automatic end_sim();
		// a receive wait that ran out in the debugger counts as a mismatch
		bad_count += i_host.stuck;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic instr(input logic [7:0] op);
		i_host.pulse(1'b0);
		i_host.put(op);
	endtask

	// indirect write of reps frames; later frames carry data only
	task automatic st(input logic [7:0] op, input int reps);
		logic [15:0] d;
		for (int i = 0; i < reps; i++)
		begin
			d = 16'($random(seed));
			if (!op[0])
				d[15:8] = 8'h00;
			expBus.push_back({op[0], ptrM, d});
			if (i == 0)
				instr(op);
			i_host.put(d[7:0]);
			if (op[0])
				i_host.put(d[15:8]);
			chk_tx(ACK_CHAR);
			if (op[3:2] == PTR_POSTINC)
				ptrM = ptrM + (op[0] ? 16'h0002 : 16'h0001);
			chk("pointer", ptrM, pointer);
		end
	endtask

	// bus side answers after busLat cycles
	always @(negedge ref_clk)
	begin
		fire = busReq && !busDone && lat >= busLat;
		lat = (busReq && !busDone && !fire) ? lat + 1 : 0;
		if (fire)
			chk("bus write", expBus.pop_front(),
				{busWide, busAddr, busWide ? busWdata : {8'h00, busWdata[7:0]}});
		busDone <= fire;
		if (csWrite)
			chk("cs write", expCs.pop_front(), {csAddr, csWdata});
		if (keyValid)
			chk("key", expKey, keyData);
		keyCnt += keyValid;
		badSeen += badOp;
	end

	initial
	begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		end_sim();
	end

	initial
	begin
		sibData = {$random(seed), $random(seed), $random(seed), $random(seed)};
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		guardIdleCount = 3'h2;
		instr(8'h69);
		i_host.put(8'hFE);
		i_host.put(8'hFF);
		ptrM = 16'hFFFE;
		chk_tx(ACK_CHAR);
		chk("pointer", ptrM, pointer);
		st(8'h65, 1);
		st(8'h60, 1);
		i_host.slow = 1;
		guardIdleCount = 3'h0;
		st(8'h61, 1);
		st(8'h64, 1);
		i_host.slow = 0;
		instr(8'hA0);
		i_host.put(8'h02);
		st(8'h64, 3);
		instr(8'hA0);
		i_host.put(8'hFF);
		st(8'h60, 256);
		chk("repeatActive", 0, repeatActive);
		// a stray byte after the last frame must not start a write
		i_host.put(8'h5A);
		instr(8'hA0);
		i_host.put(8'h05);
		instr(8'hA0);
		i_host.put(8'h00);
		st(8'h60, 1);
		i_host.put(8'h5A);
		instr(8'hA0);
		i_host.put(8'h01);
		instr(8'hC7);
		for (int i = 0; i < 2; i++)
		begin
			expCs.push_back({4'h7, 8'(i + 8'h31)});
			i_host.put(8'(i + 8'h31));
		end
		repeat (10) @(negedge ref_clk);
		for (int a = 0; a < 16; a++)
		begin
			guardIdleCount = 3'(a);
			instr(8'h80 | 8'(a));
			chk_tx({4'h5, 4'(a)});
		end
		instr(8'hA0);
		i_host.put(8'h01);
		instr(8'h83);
		chk_tx(8'h53);
		chk_tx(8'h53);
		expKey = {$random(seed), $random(seed)};
		instr(8'hE0);
		for (int i = 0; i < 8; i++)
			i_host.put(expKey[8*i+:8]);
		repeat (10) @(negedge ref_clk);
		chk("key count", 1, keyCnt);
		guardIdleCount = 3'h7;
		i_host.slow = 1;
		instr(8'hE5);
		for (int i = 0; i < 16; i++)
			chk_tx(sibData[8*i+:8]);
		i_host.slow = 0;
		instr(8'hE4);
		for (int i = 0; i < 8; i++)
			chk_tx(sibData[8*i+:8]);
		foreach (badOps[i])
		begin
			instr(badOps[i]);
			i_host.put(8'h3C);
			repeat (4) @(negedge ref_clk);
			badM++;
			chk("badOp count", badM, badSeen);
		end
		repeat (8) @(negedge ref_clk);
		guardIdleCount = 3'h1;
		instr(8'hA0);
		i_host.put(8'h05);
		st(8'h64, 2);
		chk("repeatActive", 1, repeatActive);
		i_host.pulse(1'b1);
		chk("repeatActive", 0, repeatActive);
		i_host.put(8'h11);
		// stall the bus while the debugger fills the receive fifo
		busLat = 80;
		st(8'h60, 0);
		expBus.push_back({1'b0, ptrM, 16'h00C3});
		instr(8'h60);
		i_host.put(8'hC3);
		for (int i = 0; i < 16; i++)
			i_host.put(8'($random(seed)));
		chk("rxReady", 0, rxReady);
		chk_tx(ACK_CHAR);
		busLat = 1;
		repeat (40) @(negedge ref_clk);
		chk("rxReady", 1, rxReady);
		chk("bus queue", 0, expBus.size());
		chk("cs queue", 0, expCs.size());
		end_sim();
	end
endmodule

bind debug_port_instruction_engine debug_port_asserts i_chk (.ref_clk(ref_clk),
	.reset(reset), .breakSeen(breakSeen), .bitTick(bitTick),
	.guardIdleCount(guardIdleCount), .txValid(txValid), .txData(txData),
	.txReady(txReady), .txTurn(txTurn), .busReq(busReq), .busAddr(busAddr),
	.busWdata(busWdata), .busDone(busDone), .csWrite(csWrite), .keyValid(keyValid),
	.pointer(pointer), .repeatActive(repeatActive), .badOp(badOp));
